/* File: verilog/scss_pkg.sv */
// Purpose: constants, register map and states of the system clock switch sequencer
// Assumes: 200 MHz pclk, APB word registers at byte address = index * 4
// Notes:   oscillator clocks arrive as levels sampled on pclk
// Behaviour
// RULE1 - on internal frequency change, wait for current clock fall, then force output low
// RULE2 - after forcing low, count eight falls of requested clock, then route to it
// RULE3 - slow internal to fast internal clears stable flag, sets it after about 4 ms
// RULE4 - fast to different fast internal frequency leaves stable flag set
// RULE5 - after wake or power-on apply CPU start-up; fast internal target adds 4 ms delay
// RULE6 - CPU start-up delay lasts 5 to 10 us
// RULE7 - leaving sleep or slow internal for a crystal primary runs 1024-cycle start-up timer
// RULE8 - selecting slow internal clears primary-ready, switches over, powers primary down; code powers primary down when the hold starts, before the switch
// RULE9 - no transition selecting internal when primary is configured as slow internal; code blocks it only while running on primary
// RULE10 - entering internal-run holds phase clocks in Q1 for eight internal falls
// RULE11 - entering secondary-run clears primary-ready, stops primary, sets running after eight falls
// RULE12 - software enables secondary oscillator and waits for it before selecting it
// RULE13 - secondary disabled: select writes 01 become 00, 11 becomes 10
// RULE14 - returning to crystal primary withholds the clock until 1024 primary cycles
// RULE15 - during start-up timer keep clocking from current source
// RULE16 - primary-ready set once timer expired and clock comes from primary
// RULE17 - after start-up hold Q1 for eight primary falls, then run on primary
// RULE18 - in secondary-run, clearing secondary enable clears select bit 0
// RULE19 - secondary oscillator keeps running until the switch away completes
// RULE20 - external or RC primary: 5-10 us suspend after leaving secondary clock
// RULE21 - select encodes 00 primary, 01 secondary, 10 internal, 11 reserved
// RULE22 - frequency select 000 is 31.25 kHz, 001-110 125 kHz-4 MHz, 111 is 8 MHz
// RULE23 - no new request accepted while a transition is in progress
package scss_pkg;

	// timing
	localparam int CLK_MHZ          = 200;
	localparam int STAB_TIME_MS     = 4;
	localparam int STAB_CYCLES      = STAB_TIME_MS * 1000 * CLK_MHZ;
	localparam int CPU_START_US     = 5;
	localparam int CPU_START_CYCLES = CPU_START_US * CLK_MHZ;
	localparam int OST_CYCLES       = 1024;
	localparam int HOLD_EDGES       = 8;

	// register indices and byte addresses
	localparam logic [7:0] IDX_OSC_CTRL  = 8'h8f;
	localparam logic [7:0] IDX_TIMER_ONE = 8'h90;
	localparam logic [7:0] IDX_SEQ_CFG   = 8'h91;
	localparam logic [9:0] ADDR_OSC_CTRL  = {IDX_OSC_CTRL, 2'h0};
	localparam logic [9:0] ADDR_TIMER_ONE = {IDX_TIMER_ONE, 2'h0};
	localparam logic [9:0] ADDR_SEQ_CFG   = {IDX_SEQ_CFG, 2'h0};

	// field positions
	localparam int OSC_FREQ_LSB = 4;
	localparam int OSC_PRDY_BIT = 3;
	localparam int OSC_STAB_BIT = 2;
	localparam int OSC_SEL_LSB  = 0;
	localparam int T1_EN_BIT    = 0;
	localparam int T1_RUN_BIT   = 1;
	localparam int CFG_OSC_LSB  = 0;
	localparam int CFG_WAKE_BIT = 4;
	localparam int CFG_BUSY_BIT = 5;
	localparam int CFG_SUSP_BIT = 6;
	localparam int CFG_CUR_LSB  = 8;

	// clock source select codes
	localparam logic [1:0] SRC_PRI = 2'h0;
	localparam logic [1:0] SRC_SEC = 2'h1;
	localparam logic [1:0] SRC_INT = 2'h2;
	localparam logic [1:0] SRC_RSV = 2'h3;
	localparam logic [2:0] FREQ_SLOW = 3'h0;

	// primary oscillator configuration codes
	localparam logic [2:0] POSC_LP    = 3'h0;
	localparam logic [2:0] POSC_XT    = 3'h1;
	localparam logic [2:0] POSC_HS    = 3'h2;
	localparam logic [2:0] POSC_EC    = 3'h3;
	localparam logic [2:0] POSC_RC    = 3'h4;
	localparam logic [2:0] POSC_SLOW_INTERNAL_OSC = 3'h5;

	// reset values
	localparam logic [1:0] SEL_RESET  = SRC_PRI;
	localparam logic [2:0] FREQ_RESET = FREQ_SLOW;

	typedef enum logic [2:0] {
		ST_BOOT,
		ST_IDLE,
		ST_OST,
		ST_FALL,
		ST_HOLD,
		ST_SUSP
	} scss_state_e;

endpackage

/* File: verilog/scss_sequencer.sv */
// Purpose: clock switch sequencer with APB register access
// Assumes: oscillator inputs synchronous to pclk, one APB wait state
// Notes:   the clock output is a registered, glitch-free copy of the chosen source
`timescale 1ns/10ps
module scss_sequencer #(
	parameter int         STAB_CYCLES = scss_pkg::STAB_CYCLES,
	parameter logic [2:0] POSC_RESET  = scss_pkg::POSC_XT
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        primary_clk,
	input  wire logic        secondary_oscillator,
	input  wire logic        fast_internal_osc,
	input  wire logic        slow_internal_osc,
	output logic             clock_output_pin,
	output logic             core_hold_q1,
	output logic             cpu_suspend,
	output logic             primary_osc_on,
	output logic             secondary_osc_on
);

	typedef struct packed {
		scss_pkg::scss_state_e state;
		logic [1:0]  sel;
		logic [2:0]  freq;
		logic [2:0]  posc;
		logic        sec_en;
		logic        secondary_run_mode;
		logic        pri_rdy;
		logic        int_stable;
		logic [1:0]  cur_src;
		logic [2:0]  cur_freq;
		logic [1:0]  tgt_src;
		logic [2:0]  tgt_freq;
		logic [10:0] startup_timer;
		logic        ost_done;
		logic [10:0] dly;
		logic [19:0] stab;
		logic        need_stab;
		logic        susp_after;
		logic        prev_pri;
		logic        prev_sec;
		logic        prev_fast;
		logic        prev_slow;
		logic        clk_out;
		logic        gate;
		logic        hold_q1;
		logic        suspend;
		logic        pri_on;
		logic        sec_on;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} scss_st_s;

	scss_st_s st_ff;
	scss_st_s nxt_st;

	// crystal primaries need the start-up timer
	function automatic logic is_crystal(input logic [2:0] cfg);
		return (cfg == scss_pkg::POSC_LP) || (cfg == scss_pkg::POSC_XT) || (cfg == scss_pkg::POSC_HS);
	endfunction

	// level of the physical clock behind a source and frequency
	function automatic logic src_level(input logic [1:0] src, input logic [2:0] frq, input logic [2:0] cfg,
		input logic pri, input logic sec, input logic fst, input logic slw);
		logic lvl;
		lvl = 1'b0;
		case (src)
			scss_pkg::SRC_PRI: lvl = (cfg == scss_pkg::POSC_SLOW_INTERNAL_OSC) ? slw : pri;
			scss_pkg::SRC_SEC: lvl = sec;
			scss_pkg::SRC_INT: lvl = (frq == scss_pkg::FREQ_SLOW) ? slw : fst; // see RULE22
			default:           lvl = 1'b0;
		endcase
		return lvl;
	endfunction

	// select write: reserved code always, secondary code with the secondary disabled
	function automatic logic [1:0] fix_sel(input logic [1:0] req, input logic en);
		logic [1:0] res;
		res = req;
		if (req == scss_pkg::SRC_RSV) begin
			res = scss_pkg::SRC_INT; // see RULE13
		end else if (req == scss_pkg::SRC_SEC && !en) begin
			res = scss_pkg::SRC_PRI; // see RULE13
		end
		return res;
	endfunction

	logic cur_now;
	logic cur_fall;
	logic tgt_fall;
	logic pri_fall;
	logic need_switch;
	logic wr_go;
	logic rd_go;
	logic hit;

	// falling edges of the running, requested and primary clocks
	assign cur_now  = src_level(st_ff.cur_src, st_ff.cur_freq, st_ff.posc, primary_clk,
		secondary_oscillator, fast_internal_osc, slow_internal_osc);
	assign cur_fall = !cur_now && src_level(st_ff.cur_src, st_ff.cur_freq, st_ff.posc,
		st_ff.prev_pri, st_ff.prev_sec, st_ff.prev_fast, st_ff.prev_slow);
	assign tgt_fall = !src_level(st_ff.tgt_src, st_ff.tgt_freq, st_ff.posc, primary_clk,
		secondary_oscillator, fast_internal_osc, slow_internal_osc)
		&& src_level(st_ff.tgt_src, st_ff.tgt_freq, st_ff.posc,
		st_ff.prev_pri, st_ff.prev_sec, st_ff.prev_fast, st_ff.prev_slow);
	assign pri_fall = st_ff.prev_pri && !primary_clk;

	// does the selection differ from what runs now
	always_comb begin
		need_switch = (st_ff.sel != st_ff.cur_src)
			|| (st_ff.sel == scss_pkg::SRC_INT && st_ff.freq != st_ff.cur_freq);
		if (st_ff.sel == scss_pkg::SRC_INT && st_ff.cur_src == scss_pkg::SRC_PRI
			&& st_ff.posc == scss_pkg::POSC_SLOW_INTERNAL_OSC) begin
			need_switch = 1'b0; // see RULE9
		end
	end

	assign wr_go = psel && penable && st_ff.pready && pwrite;
	assign rd_go = psel && penable && !st_ff.pready && !pwrite;
	assign hit   = (paddr == scss_pkg::ADDR_OSC_CTRL) || (paddr == scss_pkg::ADDR_TIMER_ONE)
		|| (paddr == scss_pkg::ADDR_SEQ_CFG);

	// next state of sequencer, flags and bus slave
	always_comb begin
		nxt_st = st_ff;
		nxt_st.prev_pri  = primary_clk;
		nxt_st.prev_sec  = secondary_oscillator;
		nxt_st.prev_fast = fast_internal_osc;
		nxt_st.prev_slow = slow_internal_osc;

		// fast internal settling delay
		if (st_ff.stab != 20'h0) begin
			nxt_st.stab = st_ff.stab - 20'h1;
			if (st_ff.stab == 20'h1) begin
				nxt_st.int_stable = 1'b1; // see RULE3
			end
		end

		case (st_ff.state)
			// power-on or wake: CPU start-up with the start-up timer in parallel
			scss_pkg::ST_BOOT: begin
				nxt_st.suspend = 1'b1;
				if (st_ff.dly != 11'(scss_pkg::CPU_START_CYCLES - 1)) begin
					nxt_st.dly = st_ff.dly + 11'h1; // see RULE5, RULE6
				end
				if (!is_crystal(st_ff.posc) || st_ff.cur_src != scss_pkg::SRC_PRI) begin
					nxt_st.ost_done = 1'b1;
				end else if (pri_fall && !st_ff.ost_done) begin
					nxt_st.startup_timer = st_ff.startup_timer + 11'h1; // see RULE7
					nxt_st.ost_done = (st_ff.startup_timer == 11'(scss_pkg::OST_CYCLES - 1));
				end
				if (st_ff.dly == 11'(scss_pkg::CPU_START_CYCLES - 1) && st_ff.ost_done) begin
					nxt_st.suspend = 1'b0;
					nxt_st.state   = scss_pkg::ST_IDLE;
					nxt_st.pri_rdy = (st_ff.cur_src == scss_pkg::SRC_PRI);
					if (st_ff.cur_src == scss_pkg::SRC_INT && st_ff.cur_freq != scss_pkg::FREQ_SLOW) begin
						nxt_st.int_stable = 1'b0; // see RULE5
						nxt_st.stab = 20'(STAB_CYCLES);
					end
				end
			end
			// evaluate the latest selection only between transitions
			scss_pkg::ST_IDLE: begin
				if (need_switch) begin // see RULE23
					nxt_st.tgt_src  = st_ff.sel;
					nxt_st.tgt_freq = st_ff.freq;
					nxt_st.startup_timer      = 11'h0;
					nxt_st.need_stab = st_ff.sel == scss_pkg::SRC_INT && st_ff.freq != scss_pkg::FREQ_SLOW
						&& !(st_ff.cur_src == scss_pkg::SRC_INT && st_ff.cur_freq != scss_pkg::FREQ_SLOW);
					nxt_st.susp_after = st_ff.sel == scss_pkg::SRC_PRI && st_ff.cur_src == scss_pkg::SRC_SEC
						&& (st_ff.posc == scss_pkg::POSC_EC || st_ff.posc == scss_pkg::POSC_RC);
					if (st_ff.sel != scss_pkg::SRC_PRI) begin
						nxt_st.pri_rdy = 1'b0; // see RULE8, RULE11
					end
					if (st_ff.sel == scss_pkg::SRC_PRI && is_crystal(st_ff.posc)) begin
						nxt_st.state = scss_pkg::ST_OST; // see RULE14
					end else begin
						nxt_st.state = scss_pkg::ST_FALL;
					end
				end
			end
			// primary starting up, old clock still drives the core
			scss_pkg::ST_OST: begin
				if (pri_fall) begin
					nxt_st.startup_timer = st_ff.startup_timer + 11'h1; // see RULE15
					if (st_ff.startup_timer == 11'(scss_pkg::OST_CYCLES - 1)) begin
						nxt_st.state = scss_pkg::ST_FALL; // see RULE14
					end
				end
			end
			// force the output low at a fall of the running clock
			scss_pkg::ST_FALL: begin
				if (cur_fall) begin
					nxt_st.gate    = 1'b0; // see RULE1
					nxt_st.hold_q1 = 1'b1;
					nxt_st.startup_timer     = 11'h0;
					nxt_st.state   = scss_pkg::ST_HOLD;
					if (st_ff.need_stab) begin
						nxt_st.int_stable = 1'b0; // see RULE3
						nxt_st.stab = 20'h0;
					end
				end
			end
			// count falls of the requested clock, then hand over
			scss_pkg::ST_HOLD: begin
				if (tgt_fall) begin
					nxt_st.startup_timer = st_ff.startup_timer + 11'h1;
					if (st_ff.startup_timer == 11'(scss_pkg::HOLD_EDGES - 1)) begin
						nxt_st.cur_src  = st_ff.tgt_src; // see RULE2, RULE10, RULE17
						nxt_st.cur_freq = st_ff.tgt_freq;
						nxt_st.gate     = 1'b1;
						nxt_st.hold_q1  = 1'b0;
						nxt_st.secondary_run_mode  = (st_ff.tgt_src == scss_pkg::SRC_SEC); // see RULE11
						nxt_st.pri_rdy  = (st_ff.tgt_src == scss_pkg::SRC_PRI); // see RULE16
						if (st_ff.need_stab) begin
							nxt_st.stab = 20'(STAB_CYCLES); // see RULE3
						end else if (st_ff.tgt_src == scss_pkg::SRC_INT && st_ff.tgt_freq != scss_pkg::FREQ_SLOW) begin
							nxt_st.int_stable = 1'b1; // see RULE4
						end
						nxt_st.dly   = 11'h0;
						nxt_st.suspend = st_ff.susp_after; // see RULE20
						nxt_st.state = st_ff.susp_after ? scss_pkg::ST_SUSP : scss_pkg::ST_IDLE;
					end
				end
			end
			// CPU start-up suspend after leaving the secondary clock
			scss_pkg::ST_SUSP: begin
				nxt_st.suspend = 1'b1; // see RULE20
				nxt_st.dly = st_ff.dly + 11'h1;
				if (st_ff.dly == 11'(scss_pkg::CPU_START_CYCLES - 1)) begin
					nxt_st.suspend = 1'b0;
					nxt_st.state   = scss_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_st.state = scss_pkg::ST_IDLE;
			end
		endcase

		// apb: one wait state, then the write lands and read data is shown
		nxt_st.pready  = psel && penable && !st_ff.pready;
		nxt_st.pslverr = psel && penable && !st_ff.pready && !hit;
		if (rd_go) begin
			nxt_st.prdata = 32'h0;
			if (paddr == scss_pkg::ADDR_OSC_CTRL) begin
				nxt_st.prdata[scss_pkg::OSC_FREQ_LSB +: 3] = st_ff.freq;
				nxt_st.prdata[scss_pkg::OSC_PRDY_BIT]      = st_ff.pri_rdy;
				nxt_st.prdata[scss_pkg::OSC_STAB_BIT]      = st_ff.int_stable;
				nxt_st.prdata[scss_pkg::OSC_SEL_LSB +: 2]  = st_ff.sel;
			end else if (paddr == scss_pkg::ADDR_TIMER_ONE) begin
				nxt_st.prdata[scss_pkg::T1_EN_BIT]  = st_ff.sec_en;
				nxt_st.prdata[scss_pkg::T1_RUN_BIT] = st_ff.secondary_run_mode;
			end else if (paddr == scss_pkg::ADDR_SEQ_CFG) begin
				nxt_st.prdata[scss_pkg::CFG_OSC_LSB +: 3]  = st_ff.posc;
				nxt_st.prdata[scss_pkg::CFG_BUSY_BIT]      = (st_ff.state != scss_pkg::ST_IDLE);
				nxt_st.prdata[scss_pkg::CFG_SUSP_BIT]      = st_ff.suspend;
				nxt_st.prdata[scss_pkg::CFG_CUR_LSB +: 2]  = st_ff.cur_src;
			end
		end
		if (wr_go && paddr == scss_pkg::ADDR_OSC_CTRL) begin
			nxt_st.freq = pwdata[scss_pkg::OSC_FREQ_LSB +: 3];
			nxt_st.sel  = fix_sel(pwdata[scss_pkg::OSC_SEL_LSB +: 2], st_ff.sec_en); // see RULE13, RULE21
		end
		if (wr_go && paddr == scss_pkg::ADDR_TIMER_ONE) begin
			nxt_st.sec_en = pwdata[scss_pkg::T1_EN_BIT];
			if (!pwdata[scss_pkg::T1_EN_BIT] && st_ff.sel == scss_pkg::SRC_SEC) begin
				nxt_st.sel = {st_ff.sel[1], 1'b0}; // see RULE18
			end
		end
		if (wr_go && paddr == scss_pkg::ADDR_SEQ_CFG) begin
			nxt_st.posc = pwdata[scss_pkg::CFG_OSC_LSB +: 3];
			if (pwdata[scss_pkg::CFG_WAKE_BIT] && st_ff.state == scss_pkg::ST_IDLE) begin
				nxt_st.state    = scss_pkg::ST_BOOT; // see RULE5
				nxt_st.suspend  = 1'b1; // see RULE6
				nxt_st.dly      = 11'h0;
				nxt_st.startup_timer      = 11'h0;
				nxt_st.ost_done = 1'b0;
			end
		end

		// oscillator power: the secondary stays up until the handover, the primary stops when the hold starts
		nxt_st.pri_on = (st_ff.cur_src == scss_pkg::SRC_PRI)
			? !(nxt_st.state == scss_pkg::ST_HOLD && st_ff.tgt_src != scss_pkg::SRC_PRI) // see RULE8, RULE11
			: (nxt_st.state != scss_pkg::ST_IDLE && st_ff.tgt_src == scss_pkg::SRC_PRI);
		nxt_st.sec_on = nxt_st.sec_en || (nxt_st.cur_src == scss_pkg::SRC_SEC) // see RULE19
			|| (nxt_st.state != scss_pkg::ST_IDLE && st_ff.tgt_src == scss_pkg::SRC_SEC); // see RULE12
		nxt_st.clk_out = st_ff.gate && cur_now;
	end

	// single state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff          <= '0;
			st_ff.state    <= scss_pkg::ST_BOOT;
			st_ff.sel      <= scss_pkg::SEL_RESET;
			st_ff.freq     <= scss_pkg::FREQ_RESET;
			st_ff.posc     <= POSC_RESET;
			st_ff.cur_src  <= scss_pkg::SRC_PRI;
			st_ff.cur_freq <= scss_pkg::FREQ_RESET;
			st_ff.tgt_src  <= scss_pkg::SRC_PRI;
			st_ff.gate     <= 1'b1;
			st_ff.suspend  <= 1'b1;
			st_ff.pri_on   <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prdata           = st_ff.prdata;
	assign pready           = st_ff.pready;
	assign pslverr          = st_ff.pslverr;
	assign clock_output_pin = st_ff.clk_out;
	assign core_hold_q1     = st_ff.hold_q1;
	assign cpu_suspend      = st_ff.suspend;
	assign primary_osc_on   = st_ff.pri_on;
	assign secondary_osc_on = st_ff.sec_on;

endmodule

/* File: tb/scss_sequencer_props.sv */
// Purpose: concurrent checks on the clock switch sequencer ports
// Assumes: oscillator periods of 6 to 16 pclk cycles in the bench
// Notes:   hold and suspend lengths are counted in helper registers
`timescale 1ns/10ps
module scss_sequencer_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [9:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        primary_clk,
	input wire logic        secondary_oscillator,
	input wire logic        fast_internal_osc,
	input wire logic        slow_internal_osc,
	input wire logic        clock_output_pin,
	input wire logic        core_hold_q1,
	input wire logic        cpu_suspend,
	input wire logic        primary_osc_on,
	input wire logic        secondary_osc_on
);
	int hold_len_ff;
	int susp_len_ff;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// lengths of the q1 hold and of the cpu suspend
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_len_ff <= 0;
			susp_len_ff <= 0;
		end else begin
			hold_len_ff <= core_hold_q1 ? hold_len_ff + 1 : 0;
			susp_len_ff <= cpu_suspend ? susp_len_ff + 1 : 0;
		end
	end

	// bus answer timing and refusals
	wait_state_a: assert property (psel && penable && !pready |=> pready) else $error("no answer after one wait");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	err_data_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data not zero");
	// switch sequence
	out_low_hold_a: assert property (core_hold_q1 && $past(core_hold_q1) |-> !clock_output_pin)
		else $error("clock output not forced low in hold");
	hold_min_a: assert property ($fell(core_hold_q1) |-> hold_len_ff >= 40)
		else $error("hold released before eight falls");
	hold_max_a: assert property ($rose(core_hold_q1) |-> ##[1:200] !core_hold_q1)
		else $error("hold never released");
	suspend_len_a: assert property ($fell(cpu_suspend) |-> susp_len_ff >= 1000)
		else $error("cpu suspend too short");
	sec_kept_a: assert property (core_hold_q1 |-> !$fell(secondary_osc_on))
		else $error("secondary stopped during switch");

	cover property ($rose(core_hold_q1));
	cover property ($fell(cpu_suspend));
	cover property (pslverr);
	cover property ($fell(secondary_osc_on));
endmodule

/* File: tb/testbench.sv */
// Purpose: directed bench for the clock switch sequencer over APB
// Assumes: oscillators made from a pclk counter, short stabilisation count
// Notes:   each wait is bounded and ends in the closing report
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [9:0]  paddr = 10'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, clock_output_pin, core_hold_q1, cpu_suspend;
	logic        primary_osc_on, secondary_osc_on, hold_seen = 1'b0, susp_seen = 1'b0;
	logic        pri = 1'b0, sec = 1'b0, fst = 1'b0, slw = 1'b0, pl;
	int          cyc = 0, mismatches = 0, n_tests = 0, n;
	localparam logic [9:0] OSC = scss_pkg::ADDR_OSC_CTRL, TMR = scss_pkg::ADDR_TIMER_ONE, CFG = scss_pkg::ADDR_SEQ_CFG;

	scss_sequencer #(.STAB_CYCLES(50), .POSC_RESET(scss_pkg::POSC_XT)) i_scss_sequencer (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.primary_clk(pri), .secondary_oscillator(sec), .fast_internal_osc(fst),
		.slow_internal_osc(slw), .clock_output_pin(clock_output_pin), .core_hold_q1(core_hold_q1),
		.cpu_suspend(cpu_suspend), .primary_osc_on(primary_osc_on), .secondary_osc_on(secondary_osc_on));

	// clock and oscillator levels, periods 8, 16, 6 and 10 pclk
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		pri <= cyc[2];
		sec <= cyc[3];
		fst <= (cyc % 6) < 3;
		slw <= (cyc % 10) < 5;
		if (core_hold_q1 === 1'b1) hold_seen <= 1'b1;
		if (cpu_suspend === 1'b1) susp_seen <= 1'b1;
	end

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin mismatches++; report_and_stop(); end
		rd = prdata; err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rchk(input logic [9:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		`CHK(rd & m, exp)
	endtask

	// poll the busy bit until the sequence is over
	task automatic wait_idle();
		n = 0;
		do begin apb(1'b0, CFG, 32'h0); n++; end while (rd[scss_pkg::CFG_BUSY_BIT] !== 1'b0 && n < 5000);
		if (n >= 5000) begin mismatches++; report_and_stop(); end
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK(cpu_suspend, 1'b1)
		n = 0;
		while (cpu_suspend !== 1'b0 && n < 12000) begin @(posedge pclk); n++; end
		`CHK(n >= 8180 && n < 9000, 1'b1)
		if (n >= 12000) report_and_stop();
		rchk(OSC, 32'hffffffff, 32'h8);
		rchk(CFG, 32'hffffffff, 32'h1);
		rchk(10'h0, 32'hffffffff, 32'h0);
		`CHK(err, 1'b1)
		// configured slow internal primary: no transition
		apb(1'b1, CFG, 32'h5);
		hold_seen = 1'b0;
		apb(1'b1, OSC, 32'h2);
		repeat (100) @(posedge pclk);
		`CHK(hold_seen, 1'b0)
		rchk(CFG, 32'h300, 32'h0);
		apb(1'b1, OSC, 32'h0);
		apb(1'b1, CFG, 32'h1);
		// internal run on the slow source
		hold_seen = 1'b0;
		apb(1'b1, OSC, 32'h2);
		wait_idle();
		`CHK(hold_seen, 1'b1)
		rchk(OSC, 32'hffffffff, 32'h2);
		`CHK(primary_osc_on, 1'b0)
		rchk(CFG, 32'h300, 32'h200);
		// slow to fast, then fast to fast
		apb(1'b1, OSC, 32'h72);
		wait_idle();
		rchk(OSC, 32'hffffffff, 32'h72);
		repeat (60) @(posedge pclk);
		rchk(OSC, 32'hffffffff, 32'h76);
		apb(1'b1, OSC, 32'h42);
		wait_idle();
		rchk(OSC, 32'hffffffff, 32'h46);
		// select writes with the secondary disabled
		hold_seen = 1'b0;
		apb(1'b1, OSC, 32'h43);
		repeat (40) @(posedge pclk);
		`CHK(hold_seen, 1'b0)
		rchk(OSC, 32'h3, 32'h2);
		apb(1'b1, OSC, 32'h41);
		rchk(OSC, 32'h3, 32'h0);
		wait_idle();
		rchk(OSC, 32'hb, 32'h8);
		`CHK(primary_osc_on, 1'b1)
		// secondary run and leaving it by clearing the enable
		apb(1'b1, TMR, 32'h1);
		apb(1'b1, OSC, 32'h41);
		wait_idle();
		rchk(TMR, 32'hffffffff, 32'h3);
		rchk(OSC, 32'hb, 32'h1);
		`CHK(primary_osc_on, 1'b0)
		apb(1'b1, TMR, 32'h0);
		rchk(OSC, 32'h3, 32'h0);
		`CHK(secondary_osc_on, 1'b1)
		wait_idle();
		`CHK(secondary_osc_on, 1'b0)
		rchk(OSC, 32'hb, 32'h8);
		// external clock primary after secondary run
		apb(1'b1, CFG, 32'h3);
		apb(1'b1, TMR, 32'h1);
		apb(1'b1, OSC, 32'h41);
		wait_idle();
		susp_seen = 1'b0;
		apb(1'b1, OSC, 32'h40);
		wait_idle();
		`CHK(susp_seen, 1'b1)
		rchk(OSC, 32'hb, 32'h8);
		// clock output follows the running primary one cycle late
		repeat (8) begin
			@(negedge pclk);
			pl = pri;
			@(negedge pclk);
			`CHK(clock_output_pin, pl)
		end
		@(posedge pclk);
		// wake from sleep onto a fast internal frequency
		apb(1'b1, OSC, 32'h42);
		wait_idle();
		susp_seen = 1'b0;
		apb(1'b1, CFG, 32'h13);
		wait_idle();
		`CHK(susp_seen, 1'b1)
		rchk(OSC, 32'h4, 32'h0);
		repeat (60) @(posedge pclk);
		rchk(OSC, 32'h4, 32'h4);
		report_and_stop();
	end
endmodule
bind scss_sequencer scss_sequencer_props i_scss_sequencer_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.primary_clk(primary_clk), .secondary_oscillator(secondary_oscillator),
	.fast_internal_osc(fast_internal_osc), .slow_internal_osc(slow_internal_osc),
	.clock_output_pin(clock_output_pin), .core_hold_q1(core_hold_q1), .cpu_suspend(cpu_suspend),
	.primary_osc_on(primary_osc_on), .secondary_osc_on(secondary_osc_on));
